// ===== include/dac_ctrl_pkg.sv
// Purpose: shared constants and types of the dac toggle/monitor/thermal control block
// Assumes: 32-bit apb register bus, 14-bit channel codes, 40 channels
// Notes: command word layout and register offsets are used by core and bench alike
package dac_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_CHANNELS = 40;
  localparam int NUM_GROUPS = 5;
  localparam int CODE_W = 14;
  localparam int ADDR_W = 6;
  localparam int CR_W = 14;
  localparam int STAT_W = 3;

  ////////////////////////////////////////////////////////////////////////////
  // apb byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_BURST_START = 8'h04;
  localparam logic [7:0] OFF_BURST_DATA = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_STATE = 8'h14;
  localparam logic [7:0] OFF_MON_CODE = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // register select codes carried in every data write
  localparam logic [1:0] SEL_SFR = 2'h0;
  localparam logic [1:0] SEL_RESERVED = 2'h1;
  localparam logic [1:0] SEL_B = 2'h2;
  localparam logic [1:0] SEL_A = 2'h3;

  // special function addresses
  localparam logic [ADDR_W-1:0] SFR_CTRL_ADDR = 6'h0C;
  localparam logic [ADDR_W-1:0] SFR_MON_SEL_ADDR = 6'h0D;
  localparam logic [ADDR_W-1:0] SFR_SOFT_PU_ADDR = 6'h09;
  localparam logic [ADDR_W-1:0] MON_TRISTATE_CH = 6'h3F;
  localparam logic [ADDR_W-1:0] LAST_CHANNEL = 6'h27;

  // control register field positions
  localparam int CR_MONITOR_BIT = 0;
  localparam int CR_TOGGLE_LSB = 2;
  localparam int CR_THERMAL_BIT = 8;

  // status / mask bit positions
  localparam int STAT_THERMAL = 0;
  localparam int STAT_STROBE = 1;
  localparam int STAT_B_IGNORED = 2;

  // command word field positions
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 14;
  localparam int CMD_SEL_LSB = 20;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [CR_W-1:0] CR_RESET = 14'h0000;
  localparam logic [ADDR_W-1:0] MON_SEL_RESET = 6'h3F;
  localparam logic [STAT_W-1:0] MASK_RESET = 3'h0;
  localparam logic [CODE_W-1:0] CODE_RESET = 14'h0000;
  localparam logic [ADDR_W-1:0] PTR_RESET = 6'h00;

  ////////////////////////////////////////////////////////////////////////////
  // one decoded data write
  typedef struct packed {
    logic [1:0] sel;
    logic [ADDR_W-1:0] addr;
    logic [CODE_W-1:0] data;
  } dac_cmd_t;

  // synchronised pin with its edges
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } pin_state_t;

endpackage : dac_ctrl_pkg

// ===== core/pin_sampler.sv
// Purpose: bring an asynchronous pin into the pclk domain and find its edges
// Assumes: pin changes no faster than a few pclk periods
// Notes: first flop feeds only the second flop
`timescale 1ns/1ps
module pin_sampler
  import dac_ctrl_pkg::*;
(
  input wire logic pclk, // block clock
  input wire logic presetn, // async reset, active low
  input wire logic pin_in, // raw pin from outside the clock domain
  output pin_state_t pin_out // synchronised level and one-cycle edge pulses
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  assign pin_out.level = sync_reg;
  assign pin_out.rise = sync_reg & ~last_reg;
  assign pin_out.fall = ~sync_reg & last_reg;

endmodule : pin_sampler

// ===== core/dac_toggle_monitor_thermal_ctrl.sv
// Purpose: digital control of a 40-channel dac: monitor mux, a/b toggle, thermal shutdown
// Assumes: apb master in pclk domain; strobe and over-temperature arrive as raw pins
// Notes: zero-wait apb slave; a status read clears it
//
// Chosen here: the register addresses and the APB register port.
`timescale 1ns/1ps
// What this block does
// (RULE1) a monitor mux routes any one selected channel code to the monitor pin
// (RULE2) with monitor mode on, the last channel output serves as the monitor pin
// (RULE3) host turns monitor mode on before selecting a channel to monitor
// (RULE4) monitor channel address 63 releases the monitor pin to high impedance
// (RULE5) select bits 00 with channel address 001100 is a control register write
// (RULE6) five toggle group enables each cover eight consecutive channels
// (RULE7) every channel keeps separate a and b data registers
// (RULE8) b register writes are dropped unless the channel's group toggles
// (RULE9) host enables toggle, loads a, loads b, then pulses the load strobe
// (RULE10) first strobe after toggle enable drives each toggled channel from a
// (RULE11) later strobes alternate a toggled channel between a and b
// (RULE12) after toggle disable the next strobe drives the channel from a
// (RULE13) thermal shutdown acts only while the thermal guard enable is set
// (RULE14) with guard on, over-temperature powers down all output amplifiers
// (RULE15) soft power-up when cool, or clearing the guard, re-enables amplifiers
// (RULE16) the two select bits choose a, b or special function for the write
// (RULE17) auto-increment burst writes never load b registers
// (RULE18) shutdown is latched until recovery and reported as a status event
module dac_toggle_monitor_thermal_ctrl
  import dac_ctrl_pkg::*;
(
  input wire logic pclk, // block clock, 200 mhz
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready, always high
  output logic pslverr, // apb error on unmapped address or an access in the wrong direction
  input wire logic load_dac_strobe_n, // load strobe pin, active low
  input wire logic over_temp, // die over-temperature indication pin
  output logic [NUM_CHANNELS-1:0][CODE_W-1:0] channel_code, // code driving each output
  output logic last_channel_is_monitor, // last channel output carries the monitor
  output logic [CODE_W-1:0] monitor_output_pin, // code routed to the monitor pin
  output logic monitor_output_oe_n, // monitor pin driven while low
  output logic amplifiers_power_down, // all output amplifiers powered down
  output logic irq // level interrupt, unmasked status pending
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  // all storage is flip-flops; channel data registers are indexed by channel number
  logic [NUM_CHANNELS-1:0][CODE_W-1:0] a_reg;
  logic [NUM_CHANNELS-1:0][CODE_W-1:0] b_reg;
  logic [NUM_CHANNELS-1:0][CODE_W-1:0] out_reg;
  logic [NUM_CHANNELS-1:0] phase_b_reg;
  logic [NUM_GROUPS-1:0] first_pending_reg;
  logic [CR_W-1:0] cr_reg;
  logic [ADDR_W-1:0] mon_sel_reg;
  logic [ADDR_W-1:0] ptr_reg;
  logic burst_reg;
  logic shutdown_reg;
  logic [STAT_W-1:0] status_reg;
  logic [STAT_W-1:0] mask_reg;
  logic [CODE_W-1:0] mon_code_reg;
  logic mon_oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // pins

  pin_state_t strobe_pin;
  pin_state_t temp_pin;

  pin_sampler u_strobe_sampler (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(load_dac_strobe_n),
    .pin_out(strobe_pin)
  );

  pin_sampler u_temp_sampler (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(over_temp),
    .pin_out(temp_pin)
  );

  // the strobe acts on its falling edge
  wire strobe = strobe_pin.fall;
  // heat sampler wakes high; harmless while the guard is off
  wire hot = temp_pin.level;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  function automatic logic is_off(input logic [7:0] a, input logic [7:0] off);
    is_off = (a == off);
  endfunction : is_off

  function automatic logic [2:0] group_of(input logic [ADDR_W-1:0] ch);
    group_of = ch[5:3];
  endfunction : group_of

  // addresses past the last group never toggle, so no index runs out of range
  function automatic logic group_toggles(input logic [NUM_GROUPS-1:0] en,
      input logic [ADDR_W-1:0] ch);
    logic [2:0] g;
    g = group_of(ch);
    group_toggles = (g < 3'(NUM_GROUPS)) ? en[g] : 1'b0;
  endfunction : group_toggles

  // a selection with no channel behind it reads as the reset code
  function automatic logic [CODE_W-1:0] code_of(
      input logic [NUM_CHANNELS-1:0][CODE_W-1:0] codes,
      input logic [ADDR_W-1:0] ch);
    code_of = CODE_RESET;
    for (int i = 0; i < NUM_CHANNELS; i++) begin
      if (ch == ADDR_W'(i)) begin
        code_of = codes[i];
      end
    end
  endfunction : code_of

  wire access = psel & penable;
  wire wr = access & pwrite;
  wire rd = access & ~pwrite;
  wire hit_cmd = is_off(paddr, OFF_CMD);
  wire hit_bstart = is_off(paddr, OFF_BURST_START);
  wire hit_bdata = is_off(paddr, OFF_BURST_DATA);
  wire hit_status = is_off(paddr, OFF_STATUS);
  wire hit_mask = is_off(paddr, OFF_MASK);
  wire hit_state = is_off(paddr, OFF_STATE);
  wire hit_mon = is_off(paddr, OFF_MON_CODE);
  wire hit_w = hit_cmd | hit_bstart | hit_bdata | hit_mask;
  wire hit_r = hit_status | hit_mask | hit_state | hit_mon;
  // some offsets are write-only, others read-only
  wire mapped = pwrite ? hit_w : hit_r;

  // no wait states: every access phase completes in one cycle
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  ////////////////////////////////////////////////////////////////////////////
  // command source: single write or burst write at the pointer

  wire wr_cmd = wr & hit_cmd;
  wire wr_bdata = wr & hit_bdata & burst_reg;
  wire burst_ptr_ok = ptr_reg < LAST_CHANNEL + 6'h01;

  dac_cmd_t cmd;
  // a burst word carries its select in the two bits above the code
  assign cmd.sel = wr_cmd ? pwdata[CMD_SEL_LSB +: 2] : pwdata[CMD_ADDR_LSB +: 2];
  assign cmd.addr = wr_cmd ? pwdata[CMD_ADDR_LSB +: ADDR_W] : ptr_reg;
  assign cmd.data = pwdata[CMD_DATA_LSB +: CODE_W];
  wire cmd_valid = wr_cmd | (wr_bdata & burst_ptr_ok);
  wire cmd_in_burst = ~wr_cmd;

  // [RULE16] select bits steer the write
  wire cmd_sfr = cmd_valid & (cmd.sel == SEL_SFR);
  wire cmd_a = cmd_valid & (cmd.sel == SEL_A);
  wire cmd_b = cmd_valid & (cmd.sel == SEL_B);

  // [RULE5] control register write
  wire wr_ctrl = cmd_sfr & (cmd.addr == SFR_CTRL_ADDR);
  wire wr_mon_sel = cmd_sfr & (cmd.addr == SFR_MON_SEL_ADDR);
  wire soft_pu = cmd_sfr & (cmd.addr == SFR_SOFT_PU_ADDR);

  wire [CR_W-1:0] cr_next = wr_ctrl ? cmd.data : cr_reg;
  wire [NUM_GROUPS-1:0] toggle_en = cr_reg[CR_TOGGLE_LSB +: NUM_GROUPS]; // [RULE6]
  wire [NUM_GROUPS-1:0] toggle_en_next = cr_next[CR_TOGGLE_LSB +: NUM_GROUPS];
  wire monitor_on = cr_reg[CR_MONITOR_BIT];
  wire guard_on = cr_reg[CR_THERMAL_BIT];

  // [RULE8] [RULE17] b loads need a toggling group and no burst
  wire b_allowed = group_toggles(toggle_en, cmd.addr) & ~cmd_in_burst;
  wire b_ignored = cmd_b & ~b_allowed;

  ////////////////////////////////////////////////////////////////////////////
  // burst pointer

  // the pointer stops past the last channel so a long burst never wraps to 0
  wire [ADDR_W-1:0] ptr_next = (wr & hit_bstart) ? PTR_RESET :
                               (wr_bdata & burst_ptr_ok) ? ptr_reg + 6'h01 : ptr_reg;
  wire burst_next = (wr & hit_bstart) ? 1'b1 : wr_cmd ? 1'b0 : burst_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_reg <= PTR_RESET;
      burst_reg <= 1'b0;
      cr_reg <= CR_RESET;
    end else begin
      ptr_reg <= ptr_next;
      burst_reg <= burst_next;
      cr_reg <= cr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // toggle groups: a newly enabled group starts from a on its first strobe

  genvar gi;
  generate
    for (gi = 0; gi < NUM_GROUPS; gi++) begin : g_group
      wire rise = toggle_en_next[gi] & ~toggle_en[gi];
      // enabling in a strobe cycle still leaves the group pending
      wire pend_next = rise ? 1'b1 : (strobe ? 1'b0 : first_pending_reg[gi]); // [RULE10]
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          first_pending_reg[gi] <= 1'b0;
        end else begin
          first_pending_reg[gi] <= pend_next;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // channels

  // outputs move only on a load strobe; writes land in a and b alone
  genvar ci;
  generate
    for (ci = 0; ci < NUM_CHANNELS; ci++) begin : g_chan
      localparam logic [ADDR_W-1:0] CH = ADDR_W'(ci);
      localparam int GRP = ci / 8;
      wire hit = cmd.addr == CH;
      wire ld_a = cmd_a & hit; // [RULE7]
      wire ld_b = cmd_b & hit & b_allowed; // [RULE7] [RULE8]
      wire tog = toggle_en[GRP];
      wire first = first_pending_reg[GRP];
      // [RULE11] alternate between a and b; [RULE12] untoggled follows a
      wire phase_next = (tog & ~first) ? ~phase_b_reg[ci] : 1'b0;
      wire [CODE_W-1:0] pick = phase_next ? b_reg[ci] : a_reg[ci];
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          a_reg[ci] <= CODE_RESET;
          b_reg[ci] <= CODE_RESET;
          out_reg[ci] <= CODE_RESET;
          phase_b_reg[ci] <= 1'b0;
        end else begin
          if (ld_a) begin
            a_reg[ci] <= cmd.data;
          end
          if (ld_b) begin
            b_reg[ci] <= cmd.data;
          end
          if (strobe) begin
            out_reg[ci] <= pick; // [RULE10] [RULE11] [RULE12]
            phase_b_reg[ci] <= phase_next;
          end
        end
      end
    end
  endgenerate

  assign channel_code = out_reg;

  ////////////////////////////////////////////////////////////////////////////
  // monitor mux

  wire sel_valid = mon_sel_reg < LAST_CHANNEL + 6'h01;
  wire [ADDR_W-1:0] mon_sel_next = wr_mon_sel ? cmd.data[ADDR_W-1:0] : mon_sel_reg;
  // [RULE4] address 63, or any unused address, releases the pin
  wire mon_drive = monitor_on & sel_valid & (mon_sel_reg != MON_TRISTATE_CH);
  // registered copy, one cycle behind the channel code
  wire [CODE_W-1:0] mon_code_next = code_of(out_reg, mon_sel_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_sel_reg <= MON_SEL_RESET;
      mon_code_reg <= CODE_RESET;
      mon_oe_n_reg <= 1'b1;
    end else begin
      mon_sel_reg <= mon_sel_next;
      mon_code_reg <= mon_code_next; // [RULE1]
      mon_oe_n_reg <= ~mon_drive; // [RULE4]
    end
  end

  assign monitor_output_pin = mon_code_reg;
  assign monitor_output_oe_n = mon_oe_n_reg;
  assign last_channel_is_monitor = monitor_on; // [RULE2]

  ////////////////////////////////////////////////////////////////////////////
  // thermal shutdown, latched until recovery

  // clearing the guard releases the latch at the write edge, even while hot
  wire guard_next = cr_next[CR_THERMAL_BIT];
  // [RULE13] [RULE14] [RULE15] [RULE18] heat wins over a soft power-up
  wire shutdown_next = ~guard_next ? 1'b0 :
                       (guard_on & hot) ? 1'b1 :
                       (soft_pu & ~hot) ? 1'b0 : shutdown_reg;
  wire shutdown_event = shutdown_next & ~shutdown_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shutdown_reg <= 1'b0;
    end else begin
      shutdown_reg <= shutdown_next;
    end
  end

  assign amplifiers_power_down = shutdown_reg; // [RULE14]

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status: read clears, a new event in the same cycle survives

  logic [STAT_W-1:0] events;
  assign events[STAT_THERMAL] = shutdown_event; // [RULE18]
  assign events[STAT_STROBE] = strobe;
  assign events[STAT_B_IGNORED] = b_ignored;

  wire rd_status = rd & hit_status;
  wire [STAT_W-1:0] status_next = (rd_status ? {STAT_W{1'b0}} : status_reg) | events;
  wire [STAT_W-1:0] mask_next = (wr & hit_mask) ? pwdata[STAT_W-1:0] : mask_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= {STAT_W{1'b0}};
      mask_reg <= MASK_RESET;
    end else begin
      status_reg <= status_next;
      mask_reg <= mask_next;
    end
  end

  assign irq = |(status_reg & mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // read data

  // state word, low to high: control, pointer, select, shutdown, burst mode
  wire [31:0] state_word = {2'h0, burst_reg, shutdown_reg, mon_sel_reg, ptr_reg, 2'h0, cr_reg};
  wire [31:0] status_word = {{(32 - STAT_W){1'b0}}, status_reg};
  wire [31:0] mask_word = {{(32 - STAT_W){1'b0}}, mask_reg};
  wire [31:0] mon_word = {17'h00000, ~mon_oe_n_reg, mon_code_reg};

  // read data is combinational and zero outside a read access
  assign prdata = ~rd ? 32'h00000000 :
                  hit_status ? status_word :
                  hit_mask ? mask_word :
                  hit_state ? state_word :
                  hit_mon ? mon_word : 32'h00000000;

endmodule : dac_toggle_monitor_thermal_ctrl

// ===== testbench/dac_ctrl_assertions.sv
// Purpose: concurrent checks on the ports of the dac control block
// Assumes: load strobe pulses stay low for many pclk cycles
// Notes: bound to every instance of the block
`timescale 1ns/1ps
module dac_ctrl_assertions
  import dac_ctrl_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic load_dac_strobe_n, // load strobe pin
  input wire logic over_temp, // over-temperature pin
  input wire logic [NUM_CHANNELS-1:0][CODE_W-1:0] channel_code, // channel codes
  input wire logic last_channel_is_monitor, // monitor mode
  input wire logic [CODE_W-1:0] monitor_output_pin, // monitor code
  input wire logic monitor_output_oe_n, // monitor driven while low
  input wire logic amplifiers_power_down, // shutdown
  input wire logic irq // interrupt
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire access = psel && penable;
  wire wr_acc = access && pwrite;
  ////////////////////////////////////////////////////////////////////////////
  a_err_in_access: assert property (pslverr |-> access)
    else $error("pslverr outside access");
  a_rdata_idle: assert property (!access |-> prdata == 32'h0)
    else $error("prdata not zero when idle");
  a_status_wr_err: assert property (wr_acc && paddr == OFF_STATUS |-> pslverr)
    else $error("status write not refused");
  a_cmd_rd_err: assert property (access && !pwrite && paddr == OFF_CMD |-> pslverr)
    else $error("command read not refused");
  a_code_on_strobe: assert property (!$stable(channel_code) |-> !$past(load_dac_strobe_n, 2))
    else $error("codes changed without strobe");
  a_pd_cause: assert property ($rose(amplifiers_power_down) |-> $past(over_temp, 2))
    else $error("shutdown without heat");
  a_pd_latched: assert property ($fell(amplifiers_power_down) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("shutdown left without recovery write");
  a_oe_needs_mon: assert property (!monitor_output_oe_n |-> $past(last_channel_is_monitor))
    else $error("monitor driven while mode off");
  a_irq_cause: assert property ($rose(irq) |-> $rose(amplifiers_power_down) || $past(access)
    || !$past(load_dac_strobe_n, 2))
    else $error("interrupt without event");
  c_shutdown: cover property ($rose(amplifiers_power_down));
  c_code_change: cover property (!$stable(channel_code));
  c_monitor_on: cover property ($fell(monitor_output_oe_n));
endmodule : dac_ctrl_assertions

bind dac_toggle_monitor_thermal_ctrl dac_ctrl_assertions dac_ctrl_assertions_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .load_dac_strobe_n(load_dac_strobe_n), .over_temp(over_temp), .channel_code(channel_code),
  .last_channel_is_monitor(last_channel_is_monitor), .monitor_output_pin(monitor_output_pin),
  .monitor_output_oe_n(monitor_output_oe_n), .amplifiers_power_down(amplifiers_power_down),
  .irq(irq));

// ===== testbench/host_pins.sv
// Purpose: host side model that pulses the load strobe pin
// Assumes: link clock of 125 ns, unrelated in phase to pclk
// Notes: strobe is low for half a link period
`timescale 1ns/1ps
module host_pins (
  output logic load_dac_strobe_n // load strobe pin, active low
);
  logic lclk;
  initial begin
    lclk = 1'b0;
    load_dac_strobe_n = 1'b1;
    #3.3;
    forever #62.5 lclk = ~lclk;
  end
  // called only after data registers are loaded
  task automatic strobe();
    @(negedge lclk);
    load_dac_strobe_n <= 1'b0;
    @(posedge lclk);
    load_dac_strobe_n <= 1'b1;
  endtask : strobe
endmodule : host_pins

// ===== testbench/test_dac_toggle_monitor_thermal_ctrl.sv
// Purpose: self-checking bench of the dac control block
// Assumes: zero-wait apb slave; strobe from host model
// Notes: one task per scenario
`timescale 1ns/1ps
module test_dac_toggle_monitor_thermal_ctrl
  import dac_ctrl_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, over_temp, pready, pslverr;
  logic lcim, oe_n, pd, irq, strobe_n, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NUM_CHANNELS-1:0][CODE_W-1:0] code;
  logic [CODE_W-1:0] mon;
  int failures, comparisons;
  dac_toggle_monitor_thermal_ctrl dac_toggle_monitor_thermal_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .load_dac_strobe_n(strobe_n), .over_temp(over_temp), .channel_code(code),
    .last_channel_is_monitor(lcim), .monitor_output_pin(mon), .monitor_output_oe_n(oe_n),
    .amplifiers_power_down(pd), .irq(irq));
  host_pins host_pins_i (.load_dac_strobe_n(strobe_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [1:0] s, input logic [5:0] a, input logic [13:0] d);
    apb(1'b1, OFF_CMD, {10'h000, s, a, d});
  endtask : wr
  task automatic strobe();
    host_pins_i.strobe();
    repeat (20) @(posedge pclk);
  endtask : strobe
  task automatic t_reset();
    check("code0", code[0], 32'h0);
    check("oe_n", oe_n, 32'h1);
    check("irq", irq, 32'h0);
    apb(1'b0, OFF_STATE, 32'h0);
    check("mon_sel", rd[27:22], MON_TRISTATE_CH);
    check("ctrl", rd[13:0], CR_RESET);
    $display("test reset done");
  endtask : t_reset
  task automatic t_toggle();
    wr(SEL_SFR, SFR_CTRL_ADDR, 14'h0044);
    wr(SEL_A, 6'h00, 14'h01A5);
    wr(SEL_B, 6'h00, 14'h02C3);
    wr(SEL_A, 6'h08, 14'h00F0);
    wr(SEL_B, 6'h08, 14'h03FF);
    wr(SEL_A, LAST_CHANNEL, 14'h0111);
    wr(SEL_B, LAST_CHANNEL, 14'h0222);
    strobe();
    check("ch0 first", code[0], 32'h01A5);
    check("ch8 first", code[8], 32'h00F0);
    check("ch39 first", code[39], 32'h0111);
    strobe();
    check("ch0 second", code[0], 32'h02C3);
    check("ch39 second", code[39], 32'h0222);
    check("ch8 second", code[8], 32'h00F0);
    strobe();
    check("ch0 third", code[0], 32'h01A5);
    strobe();
    wr(SEL_SFR, SFR_CTRL_ADDR, 14'h0000);
    wr(SEL_RESERVED, 6'h00, 14'h1234);
    strobe();
    check("ch0 off", code[0], 32'h01A5);
    check("ch39 off", code[39], 32'h0111);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("status", rd[2:0], 32'h6);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("status clr", rd[2:0], 32'h0);
    $display("test toggle done");
  endtask : t_toggle
  task automatic t_monitor();
    wr(SEL_SFR, SFR_CTRL_ADDR, 14'h0001);
    wr(SEL_SFR, SFR_MON_SEL_ADDR, 14'h0000);
    repeat (3) @(posedge pclk);
    check("last mon", lcim, 32'h1);
    check("oe_n on", oe_n, 32'h0);
    check("mon ch0", mon, 32'h01A5);
    wr(SEL_SFR, SFR_MON_SEL_ADDR, 14'h0027);
    repeat (3) @(posedge pclk);
    check("mon ch39", mon, 32'h0111);
    apb(1'b0, OFF_MON_CODE, 32'h0);
    check("mon word", rd, 32'h00004111);
    wr(SEL_SFR, SFR_MON_SEL_ADDR, 14'h003F);
    repeat (3) @(posedge pclk);
    check("oe_n off", oe_n, 32'h1);
    $display("test monitor done");
  endtask : t_monitor
  task automatic t_thermal();
    apb(1'b1, OFF_MASK, 32'h1);
    over_temp <= 1'b1;
    repeat (10) @(posedge pclk);
    check("pd guard off", pd, 32'h0);
    wr(SEL_SFR, SFR_CTRL_ADDR, 14'h0101);
    repeat (10) @(posedge pclk);
    check("pd hot", pd, 32'h1);
    check("irq hot", irq, 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("stat hot", rd[0], 32'h1);
    @(posedge pclk);
    check("irq clr", irq, 32'h0);
    wr(SEL_SFR, SFR_SOFT_PU_ADDR, 14'h0000);
    repeat (3) @(posedge pclk);
    check("pd pu hot", pd, 32'h1);
    over_temp <= 1'b0;
    repeat (10) @(posedge pclk);
    check("pd latched", pd, 32'h1);
    wr(SEL_SFR, SFR_SOFT_PU_ADDR, 14'h0000);
    repeat (3) @(posedge pclk);
    check("pd pu cool", pd, 32'h0);
    over_temp <= 1'b1;
    repeat (10) @(posedge pclk);
    wr(SEL_SFR, SFR_CTRL_ADDR, 14'h0001);
    repeat (3) @(posedge pclk);
    check("pd guard clr", pd, 32'h0);
    over_temp <= 1'b0;
    $display("test thermal done");
  endtask : t_thermal
  task automatic t_bus();
    apb(1'b0, OFF_CMD, 32'h0);
    check("cmd rd err", err, 32'h1);
    check("cmd rd data", rd, 32'h0);
    apb(1'b1, OFF_STATUS, 32'h7);
    check("stat wr err", err, 32'h1);
    apb(1'b1, 8'h1C, 32'h7);
    check("unmapped err", err, 32'h1);
    apb(1'b0, OFF_MASK, 32'h0);
    check("mask", rd, 32'h1);
    $display("test bus done");
  endtask : t_bus
  task automatic t_burst();
    wr(SEL_SFR, SFR_CTRL_ADDR, 14'h007C);
    apb(1'b1, OFF_BURST_START, 32'h0);
    apb(1'b1, OFF_BURST_DATA, {16'h0000, SEL_A, 14'h0ABC});
    apb(1'b1, OFF_BURST_DATA, {16'h0000, SEL_B, 14'h0DEF});
    strobe();
    check("burst ch0", code[0], 32'h0ABC);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("burst b drop", rd[2], 32'h1);
    strobe();
    check("burst ch1 b", code[1], 32'h0);
    $display("test burst done");
  endtask : t_burst
  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #100000;
    failures++;
    test_done();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    over_temp = 1'b0;
    failures = 0;
    comparisons = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_toggle();
    t_monitor();
    t_thermal();
    t_bus();
    t_burst();
    test_done();
  end
endmodule : test_dac_toggle_monitor_thermal_ctrl
